// >>> src/power_path_select.v
// power path select logic: source choice, faults, boot hold, pack removal
//
// Contract
// - an input counts as present only while its detect comparator is high
// - charger enabled: adapter first, usb second, battery third; one input switch only
// - when the selected input vanishes, move to next present source or battery
// - charger enabled with input: battery switch closed only during supplement
// - supplement need flag closes the battery switch
// - charger enable low: both input switches open, battery switch closed
// - battery-forced state never reconnects inputs on pack removal
// - path status output reports which source feeds the bus
// - usb limit from select bits: 100 mA, 500 mA, 2.75 A; adapter fixed 2.75 A
// - over-voltage on either input sets a readable fault status bit
// - over-voltage never changes input switch states
// - thermal shutdown opens both input switches and closes battery switch
// - output short opens input switches and enables input pull-ups
// - normal selection resumes once the output short clears
// - battery short opens battery switch and enables bus-battery pull-up
// - battery short detection blanked while path loop node below 1 V
// - during boot hold ignore bits, keep charger on, force 100 mA limit
// - after boot hold apply current control bits, including those written meanwhile
// - pack-id current source on whenever not asleep, at programmed level
// - pack-removal held for deglitch time declares removal, closes discharge switch
// - insufficient input: reduce charge current first; code closes the battery switch in the same cycle as the reduce request
// - charge current at zero and still short: close battery switch
`timescale 1ns/100ps
`include "power_path_consts.vh"
module power_path_select #(
  parameter BOOT_CYCLES = `BOOT_HOLD_CYCLES,
  parameter DEGLITCH_CYCLES = `NO_PACK_DEGLITCH_CYCLES,
  parameter ID_LEVEL_WIDTH = 2
) (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // comparator flags (asynchronous)
  input wire ac_detect_i,
  input wire usb_detect_i,
  input wire ac_overvoltage_i,
  input wire usb_overvoltage_i,
  input wire out_short_i,
  input wire bat_short_i,
  input wire supplement_need_i,
  input wire path_loop_low_i,
  input wire thermal_shutdown_i,
  input wire no_pack_i,
  input wire charge_current_zero_i,
  // host control bits (same clock domain)
  input wire charger_enable_i,
  input wire source_select_i,
  input wire usb_high_limit_select_i,
  input wire suspend_i,
  input wire sleep_i,
  input wire [ID_LEVEL_WIDTH-1:0] pack_id_current_level_i,
  input wire overvoltage_clear_i,
  // switch commands
  output reg ac_switch_on_o,
  output reg usb_switch_on_o,
  output reg bat_switch_on_o,
  output reg in_pullup_on_o,
  output reg bat_pullup_on_o,
  output reg discharge_on_o,
  // limits and charger
  output reg [1:0] usb_limit_o,
  output wire [1:0] ac_limit_o,
  output reg charger_on_o,
  output reg charge_reduce_o,
  // pack id source
  output reg pack_id_source_on_o,
  output reg [ID_LEVEL_WIDTH-1:0] pack_id_level_o,
  // status
  output reg [1:0] path_status_o,
  output reg overvoltage_fault_o,
  output reg pack_removed_o,
  output reg boot_hold_o
);

  // ****************************************
  // synchronised comparator flags
  // ****************************************
  localparam NFLAGS = 11;
  wire [NFLAGS-1:0] flags;

  flag_sync #(
    .WIDTH(NFLAGS)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({charge_current_zero_i, no_pack_i, thermal_shutdown_i, path_loop_low_i,
      supplement_need_i, bat_short_i, out_short_i, usb_overvoltage_i,
      ac_overvoltage_i, usb_detect_i, ac_detect_i}),
    .sync_o(flags)
  );

  wire ac_present = flags[0];
  wire usb_present = flags[1];
  wire ac_ov = flags[2];
  wire usb_ov = flags[3];
  wire out_short = flags[4];
  wire bat_short_raw = flags[5];
  wire supplement = flags[6];
  wire loop_low = flags[7];
  wire thermal = flags[8];
  wire no_pack = flags[9];
  wire charge_zero = flags[10];

  // ****************************************
  // boot hold timer
  // ****************************************
  localparam BOOT_W = 16;
  reg [BOOT_W-1:0] boot_count;

  // the count stops with the hold, so it can never wrap back into it

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boot_count <= {BOOT_W{1'b0}};
      boot_hold_o <= 1'b1;
    end else if (boot_hold_o) begin
      if (boot_count == BOOT_CYCLES[BOOT_W-1:0] - 16'h0001) begin
        boot_hold_o <= 1'b0;
      end
      boot_count <= boot_count + 16'h0001;
    end
  end

  // control bits are sampled live, so writes made during the hold take effect at its end
  wire ce_eff = boot_hold_o | charger_enable_i;
  wire susp_eff = ~boot_hold_o & suspend_i;

  // ****************************************
  // pack removal deglitch
  // ****************************************
  localparam DGL_W = 16;
  reg [DGL_W-1:0] dgl_count;

  // the count parks on its last value while the pack stays away

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dgl_count <= {DGL_W{1'b0}};
      pack_removed_o <= 1'b0;
    end else if (!no_pack) begin
      dgl_count <= {DGL_W{1'b0}};
      pack_removed_o <= 1'b0;
    end else if (dgl_count == DEGLITCH_CYCLES[DGL_W-1:0] - 16'h0001) begin
      pack_removed_o <= 1'b1;
    end else begin
      dgl_count <= dgl_count + 16'h0001;
    end
  end

  // ****************************************
  // battery-forced latch
  // ****************************************
  // once the battery is forced onto the bus and the pack goes away, the bus stays off
  // the inputs until the charger is re-enabled
  reg forced_lockout;

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      forced_lockout <= 1'b0;
    end else if (ce_eff) begin
      forced_lockout <= 1'b0;
    end else if (pack_removed_o) begin
      forced_lockout <= 1'b1;
    end
  end

  // ****************************************
  // input demand
  // ****************************************
  // the charger is trimmed first; once it has nothing left to shed the trim request drops,
  // and the bus sagging below the battery closes the battery switch in either stage, so a
  // slow charge loop cannot starve the system
  reg next_reduce;
  reg next_assist;
  reg next_charger;

  always @* begin
    next_reduce = 1'b0;
    next_assist = supplement;
    next_charger = ce_eff & ~susp_eff & ~thermal & (ac_present | usb_present);
    if ((ac_present | usb_present) & ~charge_zero) begin
      next_reduce = supplement;
    end
  end

  // ****************************************
  // source selection
  // ****************************************
  wire bat_short = bat_short_raw & ~loop_low;
  reg next_ac;
  reg next_usb;
  reg next_bat;
  reg next_in_pullup;
  reg next_bat_pullup;
  reg [1:0] next_path;

  always @* begin
    next_ac = 1'b0;
    next_usb = 1'b0;
    next_bat = 1'b0;
    next_in_pullup = 1'b0;
    next_bat_pullup = 1'b0;
    next_path = `PATH_BATTERY;
    if (thermal) begin
      next_bat = 1'b1;
    end else if (out_short) begin
      next_in_pullup = 1'b1;
      next_bat = ~bat_short;
      next_bat_pullup = bat_short;
      next_path = bat_short ? `PATH_NONE : `PATH_BATTERY;
    end else if (bat_short) begin
      next_bat_pullup = 1'b1;
      if (ce_eff && !forced_lockout && ac_present) begin
        next_ac = 1'b1;
        next_path = `PATH_AC;
      end else if (ce_eff && !forced_lockout && usb_present) begin
        next_usb = 1'b1;
        next_path = `PATH_USB;
      end else begin
        next_path = `PATH_NONE;
      end
    end else if (!ce_eff || forced_lockout) begin
      next_bat = 1'b1;
    end else if (ac_present) begin
      next_ac = 1'b1;
      next_bat = next_assist;
      next_path = `PATH_AC;
    end else if (usb_present) begin
      next_usb = 1'b1;
      next_bat = next_assist;
      next_path = `PATH_USB;
    end else begin
      next_bat = 1'b1;
    end
  end

  // over-voltage flags feed status only, never the switch logic above
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ac_switch_on_o <= 1'b0;
      usb_switch_on_o <= 1'b0;
      bat_switch_on_o <= 1'b1;
      in_pullup_on_o <= 1'b0;
      bat_pullup_on_o <= 1'b0;
      path_status_o <= `PATH_BATTERY;
    end else begin
      ac_switch_on_o <= next_ac;
      usb_switch_on_o <= next_usb & ~next_ac;
      bat_switch_on_o <= next_bat;
      in_pullup_on_o <= next_in_pullup;
      bat_pullup_on_o <= next_bat_pullup;
      path_status_o <= next_path;
    end
  end

  // ****************************************
  // limits, charger, faults, pack id
  // ****************************************
  reg [1:0] next_limit;

  always @* begin
    if (boot_hold_o) begin
      next_limit = `LIMIT_100MA;
    end else if (source_select_i) begin
      next_limit = `LIMIT_2750MA;
    end else if (usb_high_limit_select_i) begin
      next_limit = `LIMIT_500MA;
    end else begin
      next_limit = `LIMIT_100MA;
    end
  end

  assign ac_limit_o = `LIMIT_2750MA;

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      usb_limit_o <= `LIMIT_100MA;
      charger_on_o <= 1'b0;
      charge_reduce_o <= 1'b0;
      overvoltage_fault_o <= 1'b0;
      pack_id_source_on_o <= 1'b0;
      pack_id_level_o <= {ID_LEVEL_WIDTH{1'b0}};
      discharge_on_o <= 1'b0;
    end else begin
      usb_limit_o <= next_limit;
      charger_on_o <= next_charger;
      charge_reduce_o <= next_reduce;
      // a new over-voltage event wins over a clear in the same cycle
      if (ac_ov | usb_ov) begin
        overvoltage_fault_o <= 1'b1;
      end else if (overvoltage_clear_i) begin
        overvoltage_fault_o <= 1'b0;
      end
      pack_id_source_on_o <= ~sleep_i;
      pack_id_level_o <= pack_id_current_level_i;
      discharge_on_o <= pack_removed_o;
    end
  end

endmodule // power_path_select

// >>> src/power_path_consts.vh
// constants for the power path select logic
`ifndef POWER_PATH_CONSTS_VH
`define POWER_PATH_CONSTS_VH

// ****************************************
// path status encoding
// ****************************************
`define PATH_BATTERY 2'h0
`define PATH_AC 2'h1
`define PATH_USB 2'h2
`define PATH_NONE 2'h3

// ****************************************
// usb input current limit codes
// ****************************************
`define LIMIT_100MA 2'h0
`define LIMIT_500MA 2'h1
`define LIMIT_2750MA 2'h2

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 50
`define BOOT_HOLD_US 1000
`define BOOT_HOLD_CYCLES ((`BOOT_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define NO_PACK_DEGLITCH_US 50
`define NO_PACK_DEGLITCH_CYCLES ((`NO_PACK_DEGLITCH_US * 1000) / `CLK_PERIOD_NS)

`endif

// >>> src/flag_sync.v
// two flip-flop synchroniser for a bank of comparator flags
`timescale 1ns/100ps
module flag_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // flags
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign sync_o = stage2;

endmodule // flag_sync

// >>> sim/analog_front_model.sv
// model of the analog comparators that feed the power path logic
`timescale 1ns/100ps
module analog_front_model (
  // bench-set analog conditions
  input wire [10:0] env_i,
  input wire id_source_on_i,
  // comparator flags
  output wire [10:0] flags_o
);
  // the pack-removal comparator only trips while the id current source lifts the pin
  assign flags_o = {env_i[10:2], env_i[1] & id_source_on_i, env_i[0]};
endmodule // analog_front_model

// >>> sim/power_path_properties.sv
// port-level properties of the power path select logic
`timescale 1ns/100ps
`include "power_path_consts.vh"
module power_path_properties #(
  parameter BOOT_CYCLES = 8,
  parameter DEGLITCH_CYCLES = 4,
  parameter ID_LEVEL_WIDTH = 2
) (
  // clock, reset and flags
  input wire sys_clk_i, input wire sys_rst_i,
  input wire ac_detect_i, input wire usb_detect_i, input wire ac_overvoltage_i,
  input wire out_short_i, input wire thermal_shutdown_i, input wire no_pack_i,
  input wire usb_overvoltage_i, input wire bat_short_i, input wire path_loop_low_i,
  // host bits
  input wire charger_enable_i, input wire source_select_i,
  input wire usb_high_limit_select_i, input wire sleep_i,
  input wire [ID_LEVEL_WIDTH-1:0] pack_id_current_level_i,
  // design outputs
  input wire ac_switch_on_o, input wire usb_switch_on_o, input wire bat_switch_on_o,
  input wire in_pullup_on_o, input wire discharge_on_o, input wire [1:0] usb_limit_o,
  input wire bat_pullup_on_o,
  input wire charger_on_o, input wire pack_id_source_on_o,
  input wire [ID_LEVEL_WIDTH-1:0] pack_id_level_o, input wire [1:0] path_status_o,
  input wire overvoltage_fault_o, input wire pack_removed_o, input wire boot_hold_o
);
  // raw count of pack-removal samples; sync delay is covered by the margin below
  reg [15:0] np_cnt;
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) np_cnt <= 16'h0000;
    else if (!no_pack_i) np_cnt <= 16'h0000;
    else if (np_cnt != 16'hffff) np_cnt <= np_cnt + 16'h0001;
  end
  // attempts launched at the edge that releases reset would see reset-time outputs
  reg rst_dly;
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rst_dly <= 1'b1;
    else rst_dly <= 1'b0;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i || rst_dly);
  a_one_input: assert property (!(ac_switch_on_o && usb_switch_on_o))
    else $error("both input switches closed");
  a_ac_first: assert property ((charger_enable_i && ac_detect_i && !thermal_shutdown_i
    && !out_short_i)[*3] |=> ac_switch_on_o && path_status_o == `PATH_AC)
    else $error("adapter not selected");
  a_usb_second: assert property ((charger_enable_i && !ac_detect_i && usb_detect_i
    && !thermal_shutdown_i && !out_short_i)[*3] |=> usb_switch_on_o && !ac_switch_on_o)
    else $error("usb not selected");
  a_enable_override: assert property ((!boot_hold_o && !charger_enable_i
    && !thermal_shutdown_i && !out_short_i)[*3] |=> !ac_switch_on_o && !usb_switch_on_o)
    else $error("input switch closed with charger disabled");
  a_thermal_off: assert property (thermal_shutdown_i[*3] |=>
    !ac_switch_on_o && !usb_switch_on_o && bat_switch_on_o)
    else $error("thermal shutdown not applied");
  a_short_pullup: assert property ((out_short_i && !thermal_shutdown_i)[*3] |=>
    !ac_switch_on_o && !usb_switch_on_o && in_pullup_on_o)
    else $error("output short not applied");
  a_ov_flag: assert property ((ac_overvoltage_i || usb_overvoltage_i)[*3] |=>
    overvoltage_fault_o)
    else $error("over-voltage status missing");
  a_boot_limit: assert property (boot_hold_o[*2] |->
    usb_limit_o == `LIMIT_100MA)
    else $error("boot hold limit wrong");
  a_boot_charger: assert property ((boot_hold_o && ac_detect_i
    && !thermal_shutdown_i)[*3] |=> charger_on_o)
    else $error("charger not kept on during boot hold");
  a_bat_short: assert property ((bat_short_i && !path_loop_low_i
    && !thermal_shutdown_i && !out_short_i)[*3] |=> !bat_switch_on_o && bat_pullup_on_o)
    else $error("battery short not applied");
  a_limit_map: assert property ((!boot_hold_o)[*3] |-> usb_limit_o ==
    ($past(source_select_i) ? `LIMIT_2750MA :
    ($past(usb_high_limit_select_i) ? `LIMIT_500MA : `LIMIT_100MA)))
    else $error("usb limit wrong");
  a_pack_id: assert property (!sleep_i |=> pack_id_source_on_o
    && pack_id_level_o == $past(pack_id_current_level_i))
    else $error("pack id source wrong");
  a_pack_gone: assert property (np_cnt >= DEGLITCH_CYCLES + 4 |->
    pack_removed_o && discharge_on_o)
    else $error("pack removal not declared");
endmodule // power_path_properties
bind power_path_select power_path_properties #(.BOOT_CYCLES(BOOT_CYCLES),
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES), .ID_LEVEL_WIDTH(ID_LEVEL_WIDTH)) u_props (.*);

// >>> sim/tb_top.sv
// self-checking testbench for the power path select logic
`timescale 1ns/100ps
`include "power_path_consts.vh"
module tb_top;
  // ****************************************
  // stimulus and observation
  // ****************************************
  reg sys_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [10:0] env = 11'h400;
  reg ce = 1'b0, sel = 1'b0, hi = 1'b1, slp = 1'b0, ovc = 1'b0, susp = 1'b1;
  reg [1:0] lvl = 2'h2;
  integer num_errors = 0, num_checks = 0, i;
  wire [10:0] f;
  wire ac_sw, usb_sw, bat_sw, in_pu, bat_pu, dis, chg_on, reduce, id_on, ov, gone, boot;
  wire [1:0] usb_lim, ac_lim, id_lvl, status;
  wire [7:0] sw = {ac_sw, usb_sw, bat_sw, in_pu, bat_pu, dis, status};
  localparam AC = 11'h400, USB = 11'h200, ACOV = 11'h100, OSH = 11'h040, BSH = 11'h020;
  localparam SUP = 11'h010, LOW = 11'h008, TH = 11'h004, NP = 11'h002, CZ = 11'h001;
  localparam UOV = 11'h080;
  always #25 sys_clk_i = ~sys_clk_i;
  analog_front_model u_analog_front_model (.env_i(env), .id_source_on_i(id_on), .flags_o(f));
  power_path_select #(.BOOT_CYCLES(8), .DEGLITCH_CYCLES(4)) u_power_path_select (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ac_detect_i(f[10]), .usb_detect_i(f[9]),
    .ac_overvoltage_i(f[8]), .usb_overvoltage_i(f[7]), .out_short_i(f[6]),
    .bat_short_i(f[5]), .supplement_need_i(f[4]), .path_loop_low_i(f[3]),
    .thermal_shutdown_i(f[2]), .no_pack_i(f[1]), .charge_current_zero_i(f[0]),
    .charger_enable_i(ce), .source_select_i(sel), .usb_high_limit_select_i(hi),
    .suspend_i(susp), .sleep_i(slp), .pack_id_current_level_i(lvl),
    .overvoltage_clear_i(ovc), .ac_switch_on_o(ac_sw), .usb_switch_on_o(usb_sw),
    .bat_switch_on_o(bat_sw), .in_pullup_on_o(in_pu), .bat_pullup_on_o(bat_pu),
    .discharge_on_o(dis), .usb_limit_o(usb_lim), .ac_limit_o(ac_lim), .charger_on_o(chg_on),
    .charge_reduce_o(reduce), .pack_id_source_on_o(id_on), .pack_id_level_o(id_lvl),
    .path_status_o(status), .overvoltage_fault_o(ov), .pack_removed_o(gone),
    .boot_hold_o(boot));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        num_errors = num_errors + 1;
      end
    end
  endtask
  // flags need two sync edges plus one output edge, so four edges is settled
  task put(input [10:0] e);
    begin
      @(posedge sys_clk_i);
      env <= e;
      repeat (4) @(posedge sys_clk_i);
      #1;
    end
  endtask
  // one clear pulse, then settle
  task clear_ov;
    begin
      @(posedge sys_clk_i);
      ovc <= 1'b1;
      @(posedge sys_clk_i);
      ovc <= 1'b0;
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // the adapter is present and suspend is set from the start; suspend matters only after the hold
  task t_boot;
    begin
      @(posedge sys_clk_i);
      #1;
      chk({boot, chg_on, usb_lim}, 4'hc);
      chk(ac_lim, `LIMIT_2750MA);
      for (i = 0; i < 40 && boot !== 1'b0; i = i + 1) @(posedge sys_clk_i);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk({boot, chg_on, usb_lim}, {2'b00, `LIMIT_500MA});
      $display("test boot done");
    end
  endtask
  task t_prio;
    begin
      @(posedge sys_clk_i);
      ce <= 1'b1;
      put(AC | USB); chk(sw, 8'h81);
      chk(chg_on, 1'b0);
      @(posedge sys_clk_i);
      susp <= 1'b0;
      put(USB); chk(sw, 8'h42);
      chk(chg_on, 1'b1);
      put(0); chk(sw, 8'h20);
      put(AC | SUP); chk(sw, 8'ha1);
      chk(reduce, 1'b1);
      put(AC | SUP | CZ); chk(bat_sw, 1'b1);
      chk(reduce, 1'b0);
      put(AC); chk(sw, 8'h81);
      $display("test priority done");
    end
  endtask
  task t_lock;
    begin
      @(posedge sys_clk_i);
      ce <= 1'b0;
      put(AC | USB); chk(sw, 8'h20);
      put(AC | USB | NP);
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk({gone, dis}, 2'b11);
      chk(sw, 8'h24);
      put(AC | USB); chk(sw, 8'h20);
      $display("test override done");
    end
  endtask
  task t_fault;
    begin
      @(posedge sys_clk_i);
      ce <= 1'b1;
      put(AC | TH); chk(sw[7:5], 3'b001);
      put(AC | OSH | BSH); chk({sw[7:6], sw[4]}, 3'b001);
      put(AC); chk(sw, 8'h81);
      put(BSH); chk(sw, 8'h0b);
      put(BSH | LOW); chk(sw, 8'h20);
      put(AC | ACOV); chk(sw, 8'h81);
      chk(ov, 1'b1);
      clear_ov;
      chk(ov, 1'b1);
      put(AC);
      clear_ov;
      chk(ov, 1'b0);
      put(AC | UOV); chk(sw, 8'h81);
      chk(ov, 1'b1);
      $display("test faults done");
    end
  endtask
  task t_host;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge sys_clk_i);
        {sel, hi} <= i[1:0];
        slp <= i[0];
        lvl <= i[1:0];
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk(usb_lim, i[1] ? `LIMIT_2750MA : (i[0] ? `LIMIT_500MA : `LIMIT_100MA));
        chk({id_on, id_lvl}, {~i[0], i[1:0]});
      end
      $display("test host bits done");
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    t_boot;
    t_prio;
    t_lock;
    t_fault;
    t_host;
    final_report;
  end
  // the whole run needs about 130 cycles
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    num_errors = num_errors + 1;
    final_report;
  end
endmodule // tb_top
